// *** verilog/socket_pm_dma_config_regs.sv ***
// Per-socket power management and slave DMA config registers
`timescale 1ns/1ps
`include "socket_pm_dma_defs.svh"
module socket_pm_dma_config_regs (
  input  wire logic                         sys_clk,
  input  wire logic                         nrst,
  input  wire logic                         bus_reset,
  input  wire socket_pm_dma_pkg::cfg_req_s  cfg_req,
  output logic [31:0]                       cfg_rdata,
  output logic                              cfg_rvalid,
  input  wire logic [1:0]                   wake_event,
  input  wire logic [1:0][1:0]              dma_request_enable,
  input  wire logic [1:0]                   dma_req,
  output logic [1:0]                        dma_ack,
  output logic [1:0]                        dma_xfer16,
  output logic [1:0]                        dma_ext_addr,
  output logic [1:0][27:0]                  dma_io_base,
  output logic [1:0][1:0]                   power_state,
  output logic                              wake_n_o,
  output logic                              wake_n_oe
);
  // ========================================================
  // Helpers
  // Merge write data into a word under byte enables
  function automatic logic [31:0] merge_be(
    input logic [31:0] old_w,
    input logic [31:0] new_w,
    input logic [3:0]  be
  );
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Any nonzero size code means a 16-bit card transfer
  function automatic logic is_16bit(input logic [1:0] code);
    return code != 2'h0;
  endfunction

  // Gate for DMA: channel on and a request enable set
  function automatic logic dma_allowed(
    input logic       ch_en,
    input logic [1:0] req_en
  );
    return ch_en && (req_en != 2'h0);
  endfunction

  // Build the read image of the control/status word
  function automatic logic [31:0] pmcsr_image(
    input socket_pm_dma_pkg::sock_regs_s s
  );
    logic [31:0] w;
    w = 32'h00000000; // Data, scale, select, 23:16 all zero
    w[`PS_LSB +: 2]   = s.pwr_state;
    w[`WAKE_EN_BIT]   = s.wake_en;
    w[`WAKE_STS_BIT]  = s.wake_sts;
    return w;
  endfunction

  // Build the read image of the slave DMA config word
  function automatic logic [31:0] dma_image(
    input socket_pm_dma_pkg::sock_regs_s s
  );
    logic [31:0] w;
    w = 32'h00000000;
    w[`DMA_BASE_LSB +: `DMA_BASE_W] = s.dma_base;
    w[`EXT_ADDR_BIT]              = s.ext_addr;
    w[`XSIZE_LSB +: 2]            = s.xsize;
    w[`CH_EN_BIT]                 = s.ch_en;
    return w;
  endfunction

  // ========================================================
  // State
  socket_pm_dma_pkg::state_s state_reg;  // Registered state
  socket_pm_dma_pkg::state_s state_next; // Next state
  logic [31:0]               merged;     // Write data merged
  logic [31:0]               cur_w;      // Addressed old word
  socket_pm_dma_pkg::sock_regs_s tgt;    // Addressed socket

  // ========================================================
  // Next-state logic
  // Writes, sticky wake handling and read return in one place
  always_comb begin
    state_next = state_reg;
    tgt        = state_reg.sock[cfg_req.sock];
    cur_w      = 32'h00000000;
    state_next.rvalid = 1'b0;
    // Old word of the addressed register, for byte merges
    case (cfg_req.addr)
      `PMCSR_OFS: begin
        cur_w = pmcsr_image(tgt);
      end
      `DMACFG_OFS: begin
        cur_w = dma_image(tgt);
      end
      default: begin
        cur_w = 32'h00000000;
      end
    endcase
    merged = merge_be(cur_w, cfg_req.wdata, cfg_req.be);
    // Bus reset clears ordinary fields only; wake bits stay
    if (bus_reset) begin
      for (int s = 0; s < `SOCKETS; s++) begin
        state_next.sock[s].pwr_state = socket_pm_dma_pkg::PS_D0;
        state_next.sock[s].dma_base  = `BASE_RESET;
        state_next.sock[s].ext_addr  = 1'b0;
        state_next.sock[s].xsize     = `XSIZE_RESET;
        state_next.sock[s].ch_en     = 1'b0;
      end
    end else if (cfg_req.wr) begin
      case (cfg_req.addr)
        `PMCSR_OFS: begin
          // All four codes accepted, D1/D2 included
          state_next.sock[cfg_req.sock].pwr_state =
            socket_pm_dma_pkg::pwr_state_e'(
              merged[`PS_LSB +: 2]);
          state_next.sock[cfg_req.sock].wake_en =
            merged[`WAKE_EN_BIT];
          // Clear only on a one in an enabled byte lane
          if (cfg_req.be[1] && cfg_req.wdata[`WAKE_STS_BIT]) begin
            state_next.sock[cfg_req.sock].wake_sts = 1'b0;
          end
        end
        `DMACFG_OFS: begin
          state_next.sock[cfg_req.sock].dma_base =
            merged[`DMA_BASE_LSB +: `DMA_BASE_W];
          state_next.sock[cfg_req.sock].ext_addr =
            merged[`EXT_ADDR_BIT];
          state_next.sock[cfg_req.sock].xsize =
            merged[`XSIZE_LSB +: 2];
          state_next.sock[cfg_req.sock].ch_en =
            merged[`CH_EN_BIT];
        end
        default: begin
          // Capability word and unknown offsets ignore writes
        end
      endcase
    end
    // Events set status whatever the enable; set beats clear
    for (int s = 0; s < `SOCKETS; s++) begin
      if (wake_event[s]) begin
        state_next.sock[s].wake_sts = 1'b1;
      end
    end
    // Reads return one cycle later
    if (cfg_req.rd) begin
      state_next.rvalid = 1'b1;
      case (cfg_req.addr)
        `CAP_OFS: begin
          state_next.rdata = `CAP_VALUE;
        end
        `PMCSR_OFS: begin
          state_next.rdata = pmcsr_image(tgt);
        end
        `DMACFG_OFS: begin
          state_next.rdata = dma_image(tgt);
        end
        default: begin
          state_next.rdata = 32'h00000000; // Unmapped reads zero
        end
      endcase
    end
    // Wake pin follows enabled pending status
    state_next.pme_oe = 1'b0;
    for (int s = 0; s < `SOCKETS; s++) begin
      if (state_next.sock[s].wake_en && state_next.sock[s].wake_sts)
      begin
        state_next.pme_oe = 1'b1;
      end
    end
  end

  // ========================================================
  // State register
  // Power-on reset is the only reset that clears wake bits
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ========================================================
  // Outputs
  assign cfg_rdata  = state_reg.rdata;
  assign cfg_rvalid = state_reg.rvalid;
  assign wake_n_o   = 1'b0;               // Open drain: pull low
  assign wake_n_oe  = state_reg.pme_oe;
  // Per-socket DMA controls from flops; dma_ack also gated by dma_req and dma_request_enable
  always_comb begin
    for (int s = 0; s < `SOCKETS; s++) begin
      dma_ack[s]      = dma_req[s] && dma_allowed(
        state_reg.sock[s].ch_en, dma_request_enable[s]);
      dma_xfer16[s]   = is_16bit(state_reg.sock[s].xsize);
      dma_ext_addr[s] = state_reg.sock[s].ext_addr;
      dma_io_base[s]  = state_reg.sock[s].dma_base;
      power_state[s]  = state_reg.sock[s].pwr_state;
    end
  end

  // ========================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_wake_gated: assert property (
    wake_n_oe |-> ((state_reg.sock[0].wake_en &&
      state_reg.sock[0].wake_sts) || (state_reg.sock[1].wake_en
      && state_reg.sock[1].wake_sts)))
    else $error("wake pin driven without enabled status");

  a_wake_sets: assert property (
    wake_event[0] |=> state_reg.sock[0].wake_sts)
    else $error("wake event did not set status");

  a_wake_clear: assert property (
    (cfg_req.wr && !bus_reset && cfg_req.addr == `PMCSR_OFS &&
     cfg_req.be[1] && cfg_req.wdata[`WAKE_STS_BIT] &&
     !wake_event[cfg_req.sock]) |=>
      !state_reg.sock[$past(cfg_req.sock)].wake_sts)
    else $error("write one did not clear status");

  a_zero_keeps: assert property (
    (state_reg.sock[1].wake_sts && !(cfg_req.wr &&
     cfg_req.sock && cfg_req.wdata[`WAKE_STS_BIT])) |=>
      state_reg.sock[1].wake_sts)
    else $error("status lost without one written");

  a_rsvd_zero: assert property (
    ($past(cfg_req.rd) && $past(cfg_req.addr) == `PMCSR_OFS)
      |-> (cfg_rvalid && cfg_rdata[31:16] == 16'h0000 &&
           cfg_rdata[14:9] == 6'h00))
    else $error("reserved pmcsr bits nonzero");

  a_cap_value: assert property (
    (cfg_req.rd && cfg_req.addr == `CAP_OFS) |=>
      (cfg_rvalid && cfg_rdata[18:16] == `PM_REV &&
       cfg_rdata[31:27] == 5'h1f))
    else $error("capability word wrong");

  a_dma_block: assert property (
    !state_reg.sock[0].ch_en |-> !dma_ack[0])
    else $error("dma granted while channel off");

  a_dma_reqen: assert property (
    (dma_request_enable[1] == 2'h0) |-> !dma_ack[1])
    else $error("dma granted with request enables off");

  a_size_map: assert property (
    dma_xfer16[0] == (state_reg.sock[0].xsize != 2'h0))
    else $error("transfer size decode wrong");

  a_sticky_rst: assert property (
    (bus_reset && state_reg.sock[0].wake_en) |=>
      (state_reg.sock[0].wake_en && power_state[0] == 2'h0 &&
       !state_reg.sock[0].ch_en))
    else $error("bus reset handling wrong");

  a_wake_sets1: assert property (
    wake_event[1] |=> state_reg.sock[1].wake_sts)
    else $error("socket 1 wake event did not set status");

  a_dma_grant: assert property (
    (dma_req[0] && state_reg.sock[0].ch_en &&
     dma_request_enable[0] != 2'h0) |-> dma_ack[0])
    else $error("dma refused although allowed");

  a_base_rst: assert property (
    bus_reset |=> (dma_io_base[0] == 28'h0000000 &&
      dma_io_base[1] == 28'h0000000 && dma_ext_addr == 2'h0 &&
      dma_xfer16 == 2'h0))
    else $error("bus reset left dma config set");

  a_size_map1: assert property (
    dma_xfer16[1] == (state_reg.sock[1].xsize != 2'h0))
    else $error("socket 1 transfer size decode wrong");

endmodule // socket_pm_dma_config_regs

// *** verilog/socket_pm_dma_defs.svh ***
// Offsets, field positions and reset values of the socket config registers
`ifndef SOCKET_PM_DMA_DEFS_SVH
`define SOCKET_PM_DMA_DEFS_SVH
// ==========================================================
// Register offsets (config space byte addresses)
`define CAP_OFS        8'h80
`define PMCSR_OFS      8'h84
`define DMACFG_OFS     8'h90
// ==========================================================
// Capability word: wake from D0..D3, D1/D2, aux, rev 001, ID 01
`define CAP_VALUE      32'hfe110001
`define PM_REV         3'h1
// ==========================================================
// Power control/status field positions
`define PS_LSB         0
`define WAKE_EN_BIT    8
`define WAKE_STS_BIT   15
// ==========================================================
// Slave DMA config field positions
`define CH_EN_BIT      0
`define XSIZE_LSB      1
`define EXT_ADDR_BIT   3
`define DMA_BASE_LSB   4
`define DMA_BASE_W     28
// ==========================================================
// Reset values
`define PS_RESET       2'h0
`define XSIZE_RESET    2'h0
`define BASE_RESET     28'h0000000
`define SOCKETS        2
`endif

// *** verilog/socket_pm_dma_pkg.sv ***
// Types shared by the socket config register bank
package socket_pm_dma_pkg;
  // ========================================================
  // Power state codes
  typedef enum logic [1:0] {
    PS_D0, PS_D1, PS_D2, PS_D3
  } pwr_state_e;
  // ========================================================
  // One socket's writable state
  typedef struct packed {
    pwr_state_e  pwr_state;  // Socket power state
    logic        wake_en;    // Wake signal enable
    logic        wake_sts;   // Sticky wake status
    logic [27:0] dma_base;   // DMA I/O base address
    logic        ext_addr;   // Extended addressing
    logic [1:0]  xsize;      // Transfer size code
    logic        ch_en;      // Channel enable
  } sock_regs_s;
  // ========================================================
  // Config access request
  typedef struct packed {
    logic        wr;         // Write strobe
    logic        rd;         // Read strobe
    logic        sock;       // Socket select
    logic [7:0]  addr;       // Byte offset
    logic [3:0]  be;         // Byte enables
    logic [31:0] wdata;      // Write data
  } cfg_req_s;
  // ========================================================
  // Whole block state
  typedef struct packed {
    sock_regs_s [1:0] sock;   // Per-socket copies
    logic [31:0]      rdata;  // Read data
    logic             rvalid; // Read data valid
    logic             pme_oe; // Wake pin driven low
  } state_s;
endpackage

// *** testbench/cfg_host_model.sv ***
// Host bridge model that issues config space reads and writes
`timescale 1ns/1ps
module cfg_host_model (
  input  wire logic                   sys_clk,
  output socket_pm_dma_pkg::cfg_req_s cfg_req,
  input  wire logic [31:0]            cfg_rdata,
  input  wire logic                   cfg_rvalid
);
  // ==========================================================
  // Access tasks, launched on the falling edge
  initial cfg_req = '0;

  // One write strobe; idle lines show the inverse so stale data never hides
  task automatic wr(input logic s, input logic [7:0] a,
                    input logic [3:0] be, input logic [31:0] d);
    @(negedge sys_clk);
    cfg_req = '{1'b1, 1'b0, s, a, be, d};
    @(negedge sys_clk);
    cfg_req = '{1'b0, 1'b0, ~s, ~a, ~be, ~d};
  endtask

  // One read strobe, then a bounded wait for the data pulse
  task automatic rd(input logic s, input logic [7:0] a,
                    output logic [31:0] d, output bit ok);
    int n;
    @(negedge sys_clk);
    cfg_req = '{1'b0, 1'b1, s, a, 4'hf, 32'h0};
    @(negedge sys_clk);
    cfg_req = '{1'b0, 1'b0, ~s, ~a, 4'h0, 32'hffffffff};
    ok = 1'b0;
    d = '0;
    for (n = 0; n < 4 && !ok; n++) begin
      if (cfg_rvalid === 1'b1) begin
        ok = 1'b1;
        d = cfg_rdata;
      end else begin
        @(negedge sys_clk);
      end
    end
  endtask
endmodule // cfg_host_model

// *** testbench/socket_pm_dma_config_regs_tb_top.sv ***
// Self-checking bench for the socket config register bank
`timescale 1ns/1ps
`include "socket_pm_dma_defs.svh"
module socket_pm_dma_config_regs_tb_top;
  // ==========================================================
  // Signals
  logic                        sys_clk = 1'b0;
  logic                        nrst;
  logic                        bus_reset;
  socket_pm_dma_pkg::cfg_req_s cfg_req;
  logic [31:0]                 cfg_rdata;
  logic                        cfg_rvalid;
  logic [1:0]                  wake_event;
  logic [1:0][1:0]             dma_request_enable;
  logic [1:0]                  dma_req;
  logic [1:0]                  dma_ack;
  logic [1:0]                  dma_xfer16;
  logic [1:0]                  dma_ext_addr;
  logic [1:0][27:0]            dma_io_base;
  logic [1:0][1:0]             power_state;
  logic                        wake_n_o;
  logic                        wake_n_oe;
  logic [31:0]                 rv;       // Last read data
  int                          error_cnt = 0;
  int                          compares = 0;

  // 20 MHz clock
  always #25 sys_clk = ~sys_clk;

  socket_pm_dma_config_regs socket_pm_dma_config_regs_i (
    .sys_clk(sys_clk), .nrst(nrst), .bus_reset(bus_reset),
    .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .wake_event(wake_event), .dma_request_enable(dma_request_enable),
    .dma_req(dma_req), .dma_ack(dma_ack), .dma_xfer16(dma_xfer16),
    .dma_ext_addr(dma_ext_addr), .dma_io_base(dma_io_base),
    .power_state(power_state), .wake_n_o(wake_n_o),
    .wake_n_oe(wake_n_oe));

  cfg_host_model cfg_host_model_i (
    .sys_clk(sys_clk), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid));

  // ==========================================================
  // Helpers
  task automatic final_report();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // A read that never answers ends the run
  task automatic rd(input logic s, input logic [7:0] a);
    bit ok;
    cfg_host_model_i.rd(s, a, rv, ok);
    if (!ok) begin
      error_cnt++;
      $display("unexpected timeout at %0t", $time);
      final_report();
    end
  endtask

  task automatic wr(input logic s, input logic [7:0] a,
                    input logic [3:0] be, input logic [31:0] d);
    cfg_host_model_i.wr(s, a, be, d);
  endtask

  // Wake event or bus reset held for one cycle
  task automatic pulse_wake(input logic [1:0] w, input logic br);
    @(negedge sys_clk);
    wake_event = w;
    bus_reset = br;
    @(negedge sys_clk);
    wake_event = 2'h0;
    bus_reset = 1'b0;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    nrst = 1'b0;
    bus_reset = 1'b0;
    wake_event = 2'h0;
    dma_request_enable = '0;
    dma_req = 2'h3;
    repeat (6) @(negedge sys_clk);
    nrst = 1'b1;
    // Reset values of both sockets
    for (int s = 0; s < 2; s++) begin
      rd(s[0], `PMCSR_OFS);
      check(rv, 32'h0);
      rd(s[0], `DMACFG_OFS);
      check(rv, 32'h0);
    end
    // Capability word, also after an attempted write
    wr(1'b0, `CAP_OFS, 4'hf, 32'h0);
    rd(1'b0, `CAP_OFS);
    check(rv[31:27], 5'h1f);
    check(rv[26:25], 2'h3);
    check(rv[19], 1'b0);
    check(rv[21], 1'b0);
    check(rv[18:16], 3'h1);
    // Every power state code is accepted
    for (int p = 0; p < 4; p++) begin
      wr(1'b0, `PMCSR_OFS, 4'h1, 32'(p));
      rd(1'b0, `PMCSR_OFS);
      check(rv, 32'(p));
      check(power_state[0], p[1:0]);
    end
    // Constant-zero fields ignore an all-ones write
    wr(1'b0, `PMCSR_OFS, 4'hf, 32'hffffffff);
    rd(1'b0, `PMCSR_OFS);
    check(rv, 32'h103);
    check(wake_n_oe, 1'b0);
    // Status sets with enable clear, pin stays quiet
    pulse_wake(2'h2, 1'b0);
    rd(1'b1, `PMCSR_OFS);
    check(rv, 32'h8000);
    check(wake_n_oe, 1'b0);
    wr(1'b1, `PMCSR_OFS, 4'h2, 32'h100);
    rd(1'b1, `PMCSR_OFS);
    check(rv, 32'h8100);
    check(wake_n_oe, 1'b1);
    check(wake_n_o, 1'b0);
    wr(1'b1, `PMCSR_OFS, 4'h2, 32'h8100);
    rd(1'b1, `PMCSR_OFS);
    check(rv, 32'h100);
    check(wake_n_oe, 1'b0);
    // Wake bits of both sockets survive a bus reset, the rest is cleared
    pulse_wake(2'h3, 1'b0);
    pulse_wake(2'h0, 1'b1);
    rd(1'b1, `PMCSR_OFS);
    check(rv, 32'h8100);
    rd(1'b0, `PMCSR_OFS);
    check(rv, 32'h8100);
    check(wake_n_oe, 1'b1);
    // Slave DMA config fields, socket 1 untouched
    wr(1'b0, `DMACFG_OFS, 4'hf, 32'h12345679);
    rd(1'b0, `DMACFG_OFS);
    check(rv, 32'h12345679);
    check(dma_io_base[0], 28'h1234567);
    check(dma_ext_addr[0], 1'b1);
    rd(1'b1, `DMACFG_OFS);
    check(rv, 32'h0);
    for (int x = 0; x < 4; x++) begin
      wr(1'b0, `DMACFG_OFS, 4'hf, {28'h1234567, 1'b0, x[1:0], 1'b1});
      check(dma_xfer16[0], x != 0);
    end
    // Grant over channel enable and both request enables
    dma_request_enable[1] = 2'h3;
    for (int c = 0; c < 2; c++) begin
      wr(1'b0, `DMACFG_OFS, 4'hf, {28'h1234567, 3'h0, c[0]});
      for (int e = 0; e < 4; e++) begin
        dma_request_enable[0] = e[1:0];
        @(negedge sys_clk);
        check(dma_ack[0], c[0] && e != 0);
        check(dma_ack[1], 1'b0);
      end
    end
    // Socket 1 enabled: request enables alone block, request must stand
    wr(1'b1, `DMACFG_OFS, 4'hf, 32'h1);
    dma_request_enable[1] = 2'h0;
    @(negedge sys_clk);
    check(dma_ack[1], 1'b0);
    dma_request_enable[1] = 2'h1;
    @(negedge sys_clk);
    check(dma_ack[1], 1'b1);
    dma_req = 2'h0;
    @(negedge sys_clk);
    check(dma_ack, 2'h0);
    dma_req = 2'h3;
    // Bus reset clears the DMA config of both sockets
    pulse_wake(2'h0, 1'b1);
    rd(1'b0, `DMACFG_OFS);
    check(rv, 32'h0);
    rd(1'b1, `DMACFG_OFS);
    check(rv, 32'h0);
    check(dma_ack, 2'h0);
    // Power-on reset in mid-run clears the sticky wake bits as well
    @(negedge sys_clk);
    nrst = 1'b0;
    repeat (2) @(negedge sys_clk);
    nrst = 1'b1;
    rd(1'b1, `PMCSR_OFS);
    check(rv, 32'h0);
    check(wake_n_oe, 1'b0);
    // Unmapped offset reads zero
    rd(1'b0, 8'ha0);
    check(rv, 32'h0);
    final_report();
  end
endmodule // socket_pm_dma_config_regs_tb_top
